// ### shared/rpc_pkg.sv
/*
 * Constants for the real-time clock run and periodic control block.
 * Assumes a 50 MHz APB clock and one oscillator tick per 32.768 kHz period.
 */
`default_nettype none
package rpc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETTLE_MAX_NS  = 91600;
    localparam int SETTLE_MAX_CYC = SETTLE_MAX_NS / CLK_PERIOD_NS;

    localparam logic [7:0] OFS_RUN_CTRL  = 8'h00;
    localparam logic [7:0] OFS_FLAG_CTRL = 8'h04;
    localparam logic [7:0] OFS_STATUS    = 8'h08;

    localparam logic [7:0] RUN_CTRL_RST  = 8'h09;
    localparam int PFLAG_BIT    = 7;
    localparam int PSEL_LSB     = 4;
    localparam int OSC_RUN_BIT  = 3;
    localparam int HALF_MIN_BIT = 2;
    localparam int DIVRST_BIT   = 1;
    localparam int CNT_RUN_BIT  = 0;
    localparam int ALM_IE_BIT   = 3;
    localparam int ALM_FLAG_BIT = 0;

    localparam int DIV_W       = 16;
    localparam int N_SEL       = 8;
    localparam int SIXTY4_LSB  = 9;
    localparam int SIXTY4_W    = 6;
    localparam logic [2:0] SEC_SEL = 3'h6;
    localparam logic [6:0] SEC_HALF = 7'h30;

    localparam int N_ALM     = 6;
    localparam int ALM_EN    = 7;
    localparam int ALM_W     = 7;

    typedef logic [2:0] rpc_sel_t;

    // Low divider bits that must all be one for interval sel to elapse
    function automatic int period_width(input int sel);
        case (sel)
            1:       period_width = 7;
            2:       period_width = 9;
            3:       period_width = 11;
            4:       period_width = 13;
            5:       period_width = 14;
            6:       period_width = 15;
            default: period_width = 16;
        endcase
    endfunction
endpackage
`default_nettype wire

// ### shared/rpc_div_if.sv
/*
 * Link between the control register logic and the divider chain.
 * Assumes both ends share pclk and presetn.
 */
`timescale 1ns/1ns
`default_nettype none
interface rpc_div_if;
    logic              osc_tick;
    logic              osc_run;
    logic              div_clear;
    logic [7:0]        period_evt;
    logic [5:0]        sixty4;
    modport ctl (output osc_tick, osc_run, div_clear, input period_evt, sixty4);
    modport div (input osc_tick, osc_run, div_clear, output period_evt, sixty4);
endinterface
`default_nettype wire

// ### rtl/rpc_divider.sv
/*
 * Divider chain: prescaler and 64 Hz counter, with periodic event pulses.
 * Assumes osc_tick is one pclk pulse per oscillator period.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_divider
    import rpc_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  presetn,
    rpc_div_if.div     dv
);
    logic [DIV_W-1:0]  cnt_q;
    logic              adv;

    // Counter-run is not seen here, only the oscillator gate
    assign adv = dv.osc_run & dv.osc_tick;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= '0;
        else if (dv.div_clear)
            cnt_q <= '0;
        else if (adv)
            cnt_q <= cnt_q + 1'b1;
    end

    assign dv.period_evt[0] = 1'b0;
    genvar g;
    generate
        for (g = 1; g < N_SEL; g++)
        begin : g_evt
            localparam int W = period_width(g);
            logic evt_q;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    evt_q <= 1'b0;
                else
                    evt_q <= adv & ~dv.div_clear & (&cnt_q[W-1:0]);
            end
            assign dv.period_evt[g] = evt_q;
        end
    endgenerate

    assign dv.sixty4 = cnt_q[SIXTY4_LSB +: SIXTY4_W];
endmodule
`default_nettype wire

// ### rtl/rpc_ctrl.sv
/*
 * Run, periodic and alarm control of a real-time clock, APB slave.
 * Assumes the calendar counters and alarm registers sit outside and
 * that clock_crystal_input is a synchronous pulse per oscillator period.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_ctrl
    import rpc_pkg::*;
#(
    parameter int SETTLE_MAX_CYC_P = SETTLE_MAX_CYC
)
(
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic                       clock_crystal_input,
    input  wire logic                       manual_rst,
    input  wire logic                       standby,
    input  wire logic [6:0]                 seconds_counter,
    input  wire logic [N_ALM-1:0][ALM_W-1:0] cal_fields,
    input  wire logic [N_ALM-1:0][7:0]      alarm_regs,
    output logic                            oscillator_run,
    output logic                            counter_run,
    output logic                            cal_write_en,
    output logic                            sec_tick,
    output logic                            sec_clear,
    output logic                            min_carry,
    output logic      [5:0]                 sixty_four_hz_counter,
    output logic                            periodic_irq,
    output logic                            alarm_irq
);
    rpc_div_if dv ();

    logic              pready_q;
    logic              pslverr_q;
    logic [31:0]       prdata_q;
    logic              periodic_flag_q;
    rpc_sel_t          periodic_select_q;
    logic              osc_run_q;
    logic              cnt_run_q;
    logic              alarm_flag_q;
    logic              alarm_irq_enable_q;
    logic              div_clear_q;
    logic              sec_tick_q;
    logic              sec_clear_q;
    logic              min_carry_q;
    logic              cal_wr_en_q;
    logic              periodic_irq_q;
    logic              alarm_irq_q;
    logic              match_q;
    logic [5:0]        sixty4_q;
    logic              acc;
    logic              wr_run;
    logic              wr_flag;
    logic              hm_wr;
    logic              per_set;
    logic              per_gen;
    logic              alarm_match;
    logic [N_ALM-1:0]  hit;
    logic [N_ALM-1:0]  ena;

    // Address decode shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [7:0] a);
        case (a)
            OFS_RUN_CTRL:  reg_sel = 2'h1;
            OFS_FLAG_CTRL: reg_sel = 2'h2;
            OFS_STATUS:    reg_sel = 2'h3;
            default:       reg_sel = 2'h0;
        endcase
    endfunction

    function automatic logic pick_evt(input logic [7:0] evt, input rpc_sel_t s);
        pick_evt = evt[s];
    endfunction

    rpc_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .dv      (dv)
    );

    assign dv.osc_tick  = clock_crystal_input;
    assign dv.osc_run   = osc_run_q;
    assign dv.div_clear = div_clear_q;

    // One wait state so read data comes from a flop
    assign acc     = psel & penable & pready_q;
    // Standby freezes the register, so writes in it are answered but dropped
    assign wr_run  = acc & pwrite & ~pslverr_q & ~standby & (reg_sel(paddr) == 2'h1);
    assign wr_flag = acc & pwrite & ~pslverr_q & ~standby & (reg_sel(paddr) == 2'h2);
    assign hm_wr   = wr_run & pwdata[HALF_MIN_BIT];
    assign per_set = pick_evt(dv.period_evt, periodic_select_q) & ~standby;
    // Standby holds the flag, so the request waits for wake-up
    assign per_gen = periodic_flag_q & (periodic_select_q != 3'h0) & ~standby;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & (reg_sel(paddr) == 2'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= '0;
        else if (psel & penable & ~pready_q & ~pwrite)
        begin
            case (reg_sel(paddr))
                2'h1:    prdata_q <= {24'h000000, periodic_flag_q, periodic_select_q,
                                      osc_run_q, 2'b00, cnt_run_q};
                2'h2:    prdata_q <= {24'h000000, 4'h0, alarm_irq_enable_q, 2'b00,
                                      alarm_flag_q};
                2'h3:    prdata_q <= {26'h0000000, sixty4_q};
                default: prdata_q <= '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            periodic_flag_q <= RUN_CTRL_RST[PFLAG_BIT];
        else if (manual_rst)
            periodic_flag_q <= 1'b0;
        else if (per_set | (wr_run & pwdata[PFLAG_BIT]))
            periodic_flag_q <= 1'b1;
        else if (wr_run | per_gen)
            periodic_flag_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            periodic_select_q <= RUN_CTRL_RST[PSEL_LSB +: 3];
        else if (manual_rst)
            periodic_select_q <= 3'h0;
        else if (wr_run)
            periodic_select_q <= pwdata[PSEL_LSB +: 3];
    end

    // Manual reset leaves both run bits alone
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_run_q <= RUN_CTRL_RST[OSC_RUN_BIT];
            cnt_run_q <= RUN_CTRL_RST[CNT_RUN_BIT];
        end
        else if (wr_run & ~manual_rst)
        begin
            osc_run_q <= pwdata[OSC_RUN_BIT];
            cnt_run_q <= pwdata[CNT_RUN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_clear_q <= 1'b0;
            sec_clear_q <= 1'b0;
            min_carry_q <= 1'b0;
        end
        else
        begin
            div_clear_q <= ~manual_rst & (hm_wr | (wr_run & pwdata[DIVRST_BIT]));
            sec_clear_q <= ~manual_rst & hm_wr;
            min_carry_q <= ~manual_rst & hm_wr & (seconds_counter >= SEC_HALF);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_tick_q  <= 1'b0;
            cal_wr_en_q <= 1'b0;
            sixty4_q    <= '0;
        end
        else
        begin
            sec_tick_q  <= dv.period_evt[SEC_SEL] & cnt_run_q;
            cal_wr_en_q <= ~cnt_run_q;
            sixty4_q    <= dv.sixty4;
        end
    end

    genvar i;
    generate
        for (i = 0; i < N_ALM; i++)
        begin : g_alm
            assign ena[i] = alarm_regs[i][ALM_EN];
            assign hit[i] = ~ena[i] | (alarm_regs[i][ALM_W-1:0] == cal_fields[i]);
        end
    endgenerate

    // An edge, so a cleared flag is not set again for the whole matching second
    assign alarm_match = (&hit) & (|ena);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_q <= 1'b0;
        else
            match_q <= alarm_match;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_flag_q <= 1'b0;
        else if (manual_rst)
            alarm_flag_q <= 1'b0;
        else if (alarm_match & ~match_q & ~standby)
            alarm_flag_q <= 1'b1;
        else if (wr_flag & ~pwdata[ALM_FLAG_BIT])
            alarm_flag_q <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_irq_enable_q <= 1'b0;
        else if (manual_rst)
            alarm_irq_enable_q <= 1'b0;
        else if (wr_flag)
            alarm_irq_enable_q <= pwdata[ALM_IE_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periodic_irq_q <= 1'b0;
            alarm_irq_q    <= 1'b0;
        end
        else
        begin
            periodic_irq_q <= per_gen;
            alarm_irq_q    <= alarm_flag_q & alarm_irq_enable_q;
        end
    end

    assign prdata                = prdata_q;
    assign pready                = pready_q;
    assign pslverr               = pslverr_q;
    assign oscillator_run        = osc_run_q;
    assign counter_run           = cnt_run_q;
    assign cal_write_en          = cal_wr_en_q;
    assign sec_tick              = sec_tick_q;
    assign sec_clear             = sec_clear_q;
    assign min_carry             = min_carry_q;
    assign sixty_four_hz_counter = sixty4_q;
    assign periodic_irq          = periodic_irq_q;
    assign alarm_irq             = alarm_irq_q;

    // Checking helpers
    logic              first_q;
    logic              hm_pend_q;
    logic [15:0]       hm_age_q;
    logic [7:0]        run_view;

    assign run_view = {periodic_flag_q, periodic_select_q, osc_run_q, 2'b00, cnt_run_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            first_q    <= 1'b1;
            hm_pend_q  <= 1'b0;
            hm_age_q   <= '0;
        end
        else
        begin
            first_q    <= 1'b0;
            // Manual reset drops the adjust, so nothing is left pending
            hm_pend_q  <= (hm_wr & ~manual_rst) | (hm_pend_q & ~sec_clear_q);
            hm_age_q   <= hm_wr ? 16'h0000 : (hm_pend_q ? hm_age_q + 1'b1 : hm_age_q);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_POR_VALUE: assert property (first_q |-> run_view == RUN_CTRL_RST)
        else $error("control register not 0x09 after power-on reset");
    AST_MANUAL_KEEP: assert property (manual_rst |=> osc_run_q == $past(osc_run_q)
        && cnt_run_q == $past(cnt_run_q) && periodic_select_q == 3'h0 && !periodic_flag_q)
        else $error("manual reset handled run or periodic bits wrongly");
    AST_STANDBY_HOLD: assert property (standby && !manual_rst |=> $stable(run_view))
        else $error("control register changed in standby");
    AST_PERIODIC_SET: assert property (per_set && !manual_rst |=> periodic_flag_q ##1 periodic_irq)
        else $error("elapsed interval did not raise the periodic flag and request");
    AST_SW_FLAG: assert property (wr_run && !manual_rst && !per_set
        |=> periodic_flag_q == $past(pwdata[PFLAG_BIT]))
        else $error("software write to periodic flag lost");
    AST_ADJUST: assert property (hm_wr && !manual_rst |=> sec_clear && div_clear_q
        && min_carry == ($past(seconds_counter) >= SEC_HALF))
        else $error("half-minute adjust gave wrong result");
    AST_SETTLE_TIME: assert property (hm_age_q < SETTLE_MAX_CYC_P[15:0])
        else $error("adjust not visible in time");
    AST_DIVRST_READ: assert property (acc && !pwrite && !pslverr && paddr == OFS_RUN_CTRL
        |-> prdata[HALF_MIN_BIT:DIVRST_BIT] == 2'b00)
        else $error("action bits did not read as zero");
    AST_HALT: assert property (!counter_run |-> ##1 !sec_tick)
        else $error("seconds tick while counters halted");
    AST_CAL_LOCK: assert property (counter_run |-> ##1 !cal_write_en)
        else $error("calendar writable while running");
    AST_ALARM: assert property (alarm_match && !match_q && !standby && !manual_rst
        && alarm_irq_enable_q && !wr_flag |=> alarm_flag_q ##1 alarm_irq)
        else $error("alarm match did not raise flag and request");
    AST_PER_CLEAR: assert property (per_gen && !per_set && !wr_run |=> !periodic_flag_q)
        else $error("periodic flag not cleared on generation");
    AST_FLAG_CLEAR: assert property (wr_flag && !pwdata[ALM_FLAG_BIT]
        && !(alarm_match && !match_q) |=> !alarm_flag_q)
        else $error("alarm flag not cleared by write of zero");

    COV_PERIODIC: cover property (per_set ##[1:3] periodic_irq);
    COV_HM_CARRY: cover property (hm_wr ##1 min_carry);
    COV_ALARM_IRQ: cover property (alarm_irq);
    COV_ERR: cover property (pready && pslverr);
endmodule
`default_nettype wire

// ### verification/rpc_ctrl_tb.sv
/*
 * Self-checking bench for rpc_ctrl: registers over APB, periodic intervals,
 * adjust, manual reset, standby and alarm.
 * Assumes rpc_pkg and oscillator ticks made here, one every two pclk cycles outside fast mode and one every cycle in it.
 */
`timescale 1ns/1ns
`default_nettype none
module rpc_ctrl_tb
    import rpc_pkg::*;
;
    logic                         pclk;
    logic                         presetn;
    logic                         psel;
    logic                         penable;
    logic                         pwrite;
    logic [7:0]                   paddr;
    logic [31:0]                  pwdata;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         clock_crystal_input;
    logic                         manual_rst;
    logic                         standby;
    logic [6:0]                   seconds_counter;
    logic [N_ALM-1:0][ALM_W-1:0]  cal_fields;
    logic [N_ALM-1:0][7:0]        alarm_regs;
    logic                         oscillator_run;
    logic                         counter_run;
    logic                         cal_write_en;
    logic                         sec_tick;
    logic                         sec_clear;
    logic                         min_carry;
    logic [5:0]                   sixty_four_hz_counter;
    logic                         periodic_irq;
    logic                         alarm_irq;
    logic                         tick_en;
    logic [31:0]                  seed;
    logic [31:0]                  rd;
    logic                         err;
    logic [7:0]                   v;
    int                           fail_count;
    int                           n_compared;
    int                           irq_n;
    int                           clr_n;
    int                           car_n;
    int                           sec_n;
    logic                         tick_fast;

    rpc_ctrl #(.SETTLE_MAX_CYC_P(8)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clock_crystal_input(clock_crystal_input),
        .manual_rst(manual_rst), .standby(standby), .seconds_counter(seconds_counter),
        .cal_fields(cal_fields), .alarm_regs(alarm_regs), .oscillator_run(oscillator_run),
        .counter_run(counter_run), .cal_write_en(cal_write_en), .sec_tick(sec_tick),
        .sec_clear(sec_clear), .min_carry(min_carry),
        .sixty_four_hz_counter(sixty_four_hz_counter), .periodic_irq(periodic_irq),
        .alarm_irq(alarm_irq));

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // One tick every second cycle; fast mode ticks every cycle to reach a second sooner
    always @(posedge pclk) clock_crystal_input <= tick_en & (tick_fast | ~clock_crystal_input);

    // Pulses counted mid-cycle, where they are settled
    always @(negedge pclk)
    begin
        if (periodic_irq === 1'b1) irq_n++;
        if (sec_clear === 1'b1) clr_n++;
        if (min_carry === 1'b1) car_n++;
        if (sec_tick === 1'b1) sec_n++;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    // Oscillator ticks per interval at 32768 ticks a second
    function automatic int ticks_for(input int sel);
        return (sel < 5) ? (32 << (2 * sel)) : (512 << sel);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("fail_count=%0d n_compared=%0d", fail_count, n_compared);
        if (fail_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
            if (n > 20)
            begin
                fail_count++;
                end_of_test();
            end
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, {24'h0, exp});
        chk(err, 1'b0);
    endtask

    task automatic run_ticks(input int n);
        @(posedge pclk);
        tick_en <= 1'b1;
        repeat (2 * n) @(posedge pclk);
        tick_en <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    initial
    begin
        #(20 * 100000);
        fail_count++;
        end_of_test();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {manual_rst, standby, tick_en, tick_fast} = '0;
        seconds_counter = 7'h00;
        cal_fields = '0;
        alarm_regs = '0;
        {fail_count, n_compared, irq_n, clr_n, car_n, sec_n} = '0;
        seed = 32'h79711C98;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chk({oscillator_run, counter_run}, 2'h3);
        rdc(8'h00, 8'h09);
        rdc(8'h04, 8'h00);
        apb(1'b0, 8'h0C, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 12; i++)
        begin
            seed = xs(seed);
            v = seed[7:0];
            if (v[6:4] != 3'h0) v[7] = 1'b0;
            apb(1'b1, 8'h00, {seed[31:8], v});
            apb(1'b1, 8'h04, {24'h0, seed[15:8]});
            rdc(8'h00, v & 8'hF9);
            rdc(8'h04, {4'h0, seed[11], 3'h0});
            chk({oscillator_run, counter_run}, {v[3], v[0]});
            chk(cal_write_en, !v[0]);
            chk(periodic_irq, 1'b0);
        end
        for (int s = 1; s < 8; s++)
        begin
            apb(1'b1, 8'h00, {24'h0, 1'b0, 3'(s), 4'hB});
            repeat (3) @(posedge pclk);
            irq_n = 0;
            if (ticks_for(s) <= 8192)
            begin
                run_ticks(ticks_for(s) - 2);
                chk(irq_n, 0);
                run_ticks(4);
                repeat (4) @(posedge pclk);
                chk(irq_n, 1);
                rdc(8'h00, {1'b0, 3'(s), 4'h9});
            end
            else
            begin
                run_ticks(4096);
                chk(irq_n, 0);
            end
        end
        apb(1'b1, 8'h00, 32'h13);
        irq_n = 0;
        run_ticks(300);
        chk({irq_n[7:0], sixty_four_hz_counter}, 14'h0);
        apb(1'b1, 8'h00, 32'h0A);
        run_ticks(3 * 512 + 4);
        chk(sixty_four_hz_counter, 6'h03);
        rdc(8'h08, 8'h03);
        rdc(8'h08, 8'h03);
        apb(1'b1, 8'h00, 32'h0B);
        sec_n = 0;
        tick_fast <= 1'b1;
        run_ticks(16384);
        tick_fast <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(sec_n, 1);
        for (int k = 0; k < 4; k++)
        begin
            v = (k == 0) ? 8'h00 : (k == 1) ? 8'h29 : (k == 2) ? 8'h30 : 8'h59;
            seconds_counter <= v[6:0];
            clr_n = 0;
            car_n = 0;
            apb(1'b1, 8'h00, 32'h0C);
            repeat (4) @(posedge pclk);
            chk({clr_n[3:0], car_n[3:0]}, {4'h1, 3'h0, k > 1});
            rdc(8'h08, 8'h00);
            rdc(8'h00, 8'h08);
        end
        apb(1'b1, 8'h00, 32'h58);
        apb(1'b1, 8'h04, 32'h08);
        @(posedge pclk);
        manual_rst <= 1'b1;
        @(posedge pclk);
        manual_rst <= 1'b0;
        rdc(8'h00, 8'h08);
        rdc(8'h04, 8'h00);
        standby <= 1'b1;
        apb(1'b1, 8'h00, 32'h31);
        standby <= 1'b0;
        rdc(8'h00, 8'h08);
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            alarm_regs <= {32'h0, 1'b0, seed[14:8], 1'b1, seed[6:0]} << (8 * k);
            cal_fields[k] <= seed[6:0] ^ 7'h01;
            cal_fields[k + 1] <= ~seed[14:8];
            apb(1'b1, 8'h04, {28'h0, k != 2, 3'h0});
            repeat (3) @(posedge pclk);
            chk(alarm_irq, 1'b0);
            cal_fields[k] <= seed[6:0];
            repeat (4) @(posedge pclk);
            chk(alarm_irq, k != 2);
            rdc(8'h04, {4'h0, k != 2, 3'h1});
            apb(1'b1, 8'h04, {28'h0, k != 2, 3'h1});
            rdc(8'h04, {4'h0, k != 2, 3'h1});
            apb(1'b1, 8'h04, 32'h0);
            repeat (3) @(posedge pclk);
            chk(alarm_irq, 1'b0);
            rdc(8'h04, 8'h00);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
